//--- dv/scs_checker.sv
// Purpose: port assertions for the clock switch and trim block
// Assumes: one clock domain, synchronous active-high reset
// Notes: attached to scs_top by the bind after the module
`timescale 1ns/100ps
`default_nettype none
module scs_checker
  import scs_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic reset, // synchronous reset
  input wire logic avs_read, // bus read
  input wire logic avs_write, // bus write
  input wire logic avs_waitrequest, // bus stall
  input wire logic avs_response_err, // unmapped answer flag
  input wire logic flash_busy, // flash active
  input wire scs_osc_ctrl_t osc_ctrl, // trims and enables
  input wire scs_clk_en_t clk_en, // clock tree enables
  input wire logic slow_rc_run, // slow rc enable
  input wire scs_sleep_t sleep_level, // sleep level
  input wire logic xtal_fail_nmi // failover pulse
);
  // ==========================================================
  // one domain, so clock and disable are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_bus_answer: // answer comes one cycle after the stall
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus answer late");
  a_err_answer:
    assert property (avs_response_err |-> avs_read && !avs_waitrequest)
      else $error("error flag outside read answer");
  a_deep_two:
    assert property ($rose(sleep_level == SCS_DEEP2) |=> !slow_rc_run)
      else $error("slow rc kept in level two");
  a_deep_one:
    assert property (sleep_level == SCS_DEEP1 |=> slow_rc_run)
      else $error("slow rc stopped in level one");
  a_periph_half:
    assert property (clk_en.periph_en |=> !clk_en.periph_en ##1
      clk_en.periph_en) else $error("peripheral enable not half rate");
  a_flash_slow:
    assert property (flash_busy [*4] ##0 clk_en.cpu_en ##1 flash_busy
      |-> !clk_en.cpu_en) else $error("cpu fast during flash work");
  a_fail_fallback:
    assert property (xtal_fail_nmi |=> !xtal_fail_nmi ##[0:3]
      !clk_en.sysclk_from_xtal) else $error("no fallback after nmi");
  a_reset_trims:
    assert property ($fell(reset) |-> ##[0:2] (osc_ctrl.bias == SCS_RST_BIAS
      && osc_ctrl.fast_tune == SCS_RST_FAST_TRIM && {osc_ctrl.khz_int,
      osc_ctrl.khz_frac} == SCS_RST_KHZ_DIV)) else $error("bad trim reset");
  a_reset_enables:
    assert property ($fell(reset) |-> (!osc_ctrl.dither_en && !osc_ctrl.xtal_en
      && !clk_en.sysclk_from_xtal) [*3]) else $error("bad enable reset");
endmodule // scs_checker
bind scs_top scs_checker u_chk (.core_clk(core_clk), .reset(reset),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
  .flash_busy(flash_busy), .osc_ctrl(osc_ctrl), .clk_en(clk_en),
  .slow_rc_run(slow_rc_run), .sleep_level(sleep_level),
  .xtal_fail_nmi(xtal_fail_nmi));
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: self-checking bench for the clock switch and trim block
// Assumes: bench is the avalon master; register model held in arrays
// Notes: measured clocks come from a divider so results are exact
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if (32'(g) !== 32'(e)) begin \
  error_cnt++; $display("[ERR] t=%0t got=%h exp=%h", $time, 32'(g), \
  32'(e)); end end
module tb_top
  import scs_pkg::*;
;
  logic core_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [15:0] avs_address = 16'h0000;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic avs_waitrequest, avs_response_err, err, xtal_fail_nmi;
  logic deep_sleep_request = 1'b0, wait_for_interrupt = 1'b0;
  logic wake_event = 1'b0, flash_busy = 1'b0, xtal_fail_async = 1'b0;
  logic amp_high_async = 1'b0, amp_low_async = 1'b0, meas_on = 1'b0;
  logic m_slow = 1'b0, m_fast = 1'b0, m_tune = 1'b0, slow_rc_run, watch_run;
  logic [2:0] div_r = 3'h0; // divider for measured clocks
  scs_osc_ctrl_t osc_ctrl;
  scs_clk_en_t clk_en;
  scs_sleep_t sleep_level;
  int error_cnt = 0, n_checks = 0, nmi_cnt = 0, i, j, p, c, r;
  integer seed = 65546;
  // register model: offsets, writable masks, current values
  logic [15:0] off_t [11] = '{SCS_OFF_SLEEP_KEEP, SCS_OFF_SLOW_TRIM,
    SCS_OFF_KHZ_DIV, SCS_OFF_BIAS, SCS_OFF_FAST_TRIM, SCS_OFF_LEVEL,
    SCS_OFF_MEAS_SEL, SCS_OFF_MEAS_RES, SCS_OFF_DITHER, SCS_OFF_XTAL,
    SCS_OFF_CPU};
  logic [15:0] msk_t [11] = '{16'h0003, 16'h000f, 16'hffff, 16'h000f,
    16'h001f, 16'h0003, 16'h0003, 16'hffff, 16'h0001, 16'h0003, 16'h0001};
  logic [31:0] mdl [11] = '{0: 32'h0000_0002, 2: 32'h0000_5000,
    3: 32'h0000_000f, 4: 32'h0000_0017, default: 32'h0000_0000};
  scs_top u_dut (.core_clk(core_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err),
    .deep_sleep_request(deep_sleep_request),
    .wait_for_interrupt(wait_for_interrupt), .wake_event(wake_event),
    .flash_busy(flash_busy), .xtal_fail_async(xtal_fail_async),
    .amp_high_async(amp_high_async), .amp_low_async(amp_low_async),
    .meas_clk_slow_async(m_slow), .meas_clk_fast_async(m_fast),
    .meas_clk_tune_async(m_tune), .ref_12m_tick(div_r[0]),
    .osc_ctrl(osc_ctrl), .clk_en(clk_en), .slow_rc_run(slow_rc_run),
    .watch_crystal_run(watch_run), .sleep_level(sleep_level),
    .xtal_fail_nmi(xtal_fail_nmi));
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  // measured clocks: periods 8, 4 and 2 cycles, quiet until enabled
  always @(posedge core_clk)
  begin
    div_r <= div_r + 3'h1;
    m_slow <= meas_on & div_r[2];
    m_fast <= meas_on & div_r[1];
    m_tune <= meas_on & div_r[0];
    if (xtal_fail_nmi === 1'b1) nmi_cnt++;
  end
  // one bus transfer: request held until the edge that sees no stall
  task automatic bus(input bit wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    err = avs_response_err;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wreg(input int k, input logic [31:0] d);
    bus(1'b1, off_t[k], d);
    if (k != 5 && k != 7) mdl[k] = d & 32'(msk_t[k]);
  endtask
  task automatic rchk(input int k);
    bus(1'b0, off_t[k], 32'h0000_0000);
    `CHK(rd, mdl[k])
  endtask
  task automatic count_en();
    p = 0;
    c = 0;
    r = 0;
    repeat (8)
    begin
      @(negedge core_clk);
      p += clk_en.periph_en;
      c += clk_en.cpu_en;
      r += clk_en.ram_en;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    finish_test();
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (i = 0; i < 11; i++) rchk(i);
    `CHK(clk_en.sysclk_from_xtal, 0)
    $display("test reset values done");
    for (i = 0; i < 44; i++)
    begin
      wreg(i % 11, $random(seed));
      rchk(i % 11);
    end
    rd = {1'b0, mdl[1][3:0], mdl[4][4:0], mdl[3][3:0], mdl[9][1], mdl[8][0],
      mdl[2][15:0]};
    `CHK(osc_ctrl, rd)
    bus(1'b0, 16'h0014, 32'h0000_0000);
    `CHK(err, 1)
    `CHK(rd, 0)
    $display("test register access done");
    for (i = 0; i < 4; i++)
    begin
      {amp_high_async, amp_low_async} <= i[1:0];
      repeat (4) @(posedge core_clk);
      mdl[5] = i;
      rchk(5);
    end
    $display("test amplitude flags done");
    for (i = 0; i < 4; i++)
    begin
      wreg(0, i);
      deep_sleep_request <= 1'b1;
      wait_for_interrupt <= 1'b1;
      @(posedge core_clk);
      wait_for_interrupt <= 1'b0;
      repeat (3) @(posedge core_clk);
      `CHK(sleep_level, i[1] ? SCS_DEEP1 : SCS_DEEP2)
      `CHK(slow_rc_run, i[1])
      `CHK(watch_run, i[0])
      wake_event <= 1'b1;
      deep_sleep_request <= 1'b0;
      @(posedge core_clk);
      wake_event <= 1'b0;
      repeat (3) @(posedge core_clk);
      `CHK(sleep_level, SCS_AWAKE)
    end
    $display("test deep sleep done");
    meas_on <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      wreg(6, i);
      repeat (i == 1 ? 2300 : 400) @(posedge core_clk);
      // one tick every second cycle: half the cycles in the window count
      mdl[7] = ((i == 1) ? 256 * 4 : (i == 0 ? 16 * 8 : 16 * 2)) / 2;
      rchk(7);
    end
    $display("test period measure done");
    for (i = 0; i < 5; i++)
    begin
      j = (i == 4) ? 7 : i;
      wreg(9, 2 | (j & 1));
      wreg(10, (j >> 1) & 1);
      flash_busy <= j[2];
      repeat (12) @(posedge core_clk);
      count_en();
      `CHK(clk_en.sysclk_from_xtal, j[0])
      `CHK(p, 4)
      `CHK(c, (j[1] && !j[2]) ? 8 : 4)
      if (!j[2]) `CHK(r, j[1] ? 4 : 8)
    end
    flash_busy <= 1'b0;
    $display("test clock rates done");
    wreg(9, 3);
    nmi_cnt = 0;
    xtal_fail_async <= 1'b1;
    repeat (8) @(posedge core_clk);
    xtal_fail_async <= 1'b0;
    `CHK(nmi_cnt, 1)
    `CHK(clk_en.sysclk_from_xtal, 0)
    mdl[9] = 2;
    rchk(9);
    $display("test crystal failover done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire

//--- rtl/scs_pkg.sv
// Purpose: constants and types for the system clock switch and trim block
// Assumes: avalon-mm slave with 32-bit data and byte addresses
// Notes: offsets are byte addresses within the block
package scs_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [15:0] SCS_OFF_SLEEP_KEEP = 16'h0008;
  localparam logic [15:0] SCS_OFF_SLOW_TRIM = 16'h000c;
  localparam logic [15:0] SCS_OFF_KHZ_DIV = 16'h0010;
  localparam logic [15:0] SCS_OFF_BIAS = 16'h4004;
  localparam logic [15:0] SCS_OFF_FAST_TRIM = 16'h4008;
  localparam logic [15:0] SCS_OFF_LEVEL = 16'h400c;
  localparam logic [15:0] SCS_OFF_MEAS_SEL = 16'h4010;
  localparam logic [15:0] SCS_OFF_MEAS_RES = 16'h4014;
  localparam logic [15:0] SCS_OFF_DITHER = 16'h4018;
  localparam logic [15:0] SCS_OFF_XTAL = 16'h401c;
  localparam logic [15:0] SCS_OFF_CPU = 16'h4020;
  // ==========================================================
  // reset values
  localparam logic [1:0] SCS_RST_SLEEP_KEEP = 2'h2;
  localparam logic [3:0] SCS_RST_SLOW_TRIM = 4'h0;
  localparam logic [15:0] SCS_RST_KHZ_DIV = 16'h5000;
  localparam logic [3:0] SCS_RST_BIAS = 4'hf;
  localparam logic [4:0] SCS_RST_FAST_TRIM = 5'h17;
  // ==========================================================
  // field positions
  localparam int SCS_BIT_SLOW_KEEP = 1;
  localparam int SCS_BIT_WATCH_KEEP = 0;
  localparam int SCS_BIT_XTAL_EN = 1;
  localparam int SCS_BIT_SRC_SEL = 0;
  localparam int SCS_BIT_HIGH_FLAG = 1;
  localparam int SCS_BIT_LOW_FLAG = 0;
  // ==========================================================
  // measurement: periods of the measured clock per result
  localparam logic [8:0] SCS_SLOW_PERIODS = 9'h010;
  localparam logic [8:0] SCS_FAST_PERIODS = 9'h100;
  localparam logic [31:0] SCS_READ_ZERO = 32'h0000_0000;
  // ==========================================================
  // measurement source encodings
  typedef enum logic [1:0] {
    SCS_MEAS_SLOW = 2'b00,
    SCS_MEAS_FAST = 2'b01,
    SCS_MEAS_TUNE = 2'b10,
    SCS_MEAS_NONE = 2'b11
  } scs_meas_t;
  // sleep level chosen on deep-sleep entry
  typedef enum logic [1:0] {
    SCS_AWAKE = 2'b00,
    SCS_DEEP1 = 2'b01,
    SCS_DEEP2 = 2'b10
  } scs_sleep_t;
  // analog control bundle to oscillators
  typedef struct packed {
    logic [3:0] slow_tune;
    logic [4:0] fast_tune;
    logic [3:0] bias;
    logic xtal_en;
    logic dither_en;
    logic [4:0] khz_int;
    logic [10:0] khz_frac;
  } scs_osc_ctrl_t;
  // clock enables produced for the clock tree
  typedef struct packed {
    logic sysclk_from_xtal;
    logic periph_en;
    logic cpu_en;
    logic ram_en;
  } scs_clk_en_t;
endpackage

//--- rtl/scs_top.sv
// Purpose: system clock switch, cpu rate, sleep keep and trim registers
// Assumes: core_clk is the chosen system clock; oscillator status is async
// Notes: clocks are produced as glitch-free enables on core_clk
// Notes on behaviour
// - slow rc off in sleep gives level two
// - slow rc kept gives level one
// - watch crystal keep bit controls deep sleep
// - kilohertz divider integer and fraction fields
// - bias trim resets to all ones
// - fast rc trim resets to 17 hex
// - amplitude comparators readable as two bits
// - measure select picks slow, fast, tune
// - result counts 12 MHz over periods
// - dither bit enables dithering, resets off
// - crystal enable bit powers crystal oscillator
// - source select routes crystal or fast rc
// - cpu rate bit gives full or half
// - ram runs double periph when bit zero
// - crystal plus fast cpu, flash drops cpu
// - peripheral clock is half system clock
// - flash activity forces cpu to periph rate
// - crystal failure falls back and raises nmi
// - after reset system runs from fast rc
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module scs_top
  import scs_pkg::*;
(
  input wire logic core_clk, // system clock, 100 MHz
  input wire logic reset, // synchronous, active high
  input wire logic [15:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output logic avs_response_err, // unmapped read address flag with answer
  input wire logic deep_sleep_request, // cpu deep sleep flag
  input wire logic wait_for_interrupt, // cpu executes wfi, pulse
  input wire logic wake_event, // wake from deep sleep, pulse
  input wire logic flash_busy, // flash program or erase active
  input wire logic xtal_fail_async, // crystal failure detect, pin
  input wire logic amp_high_async, // high comparator, pin
  input wire logic amp_low_async, // low comparator, pin
  input wire logic meas_clk_slow_async, // internal slow rc, pin
  input wire logic meas_clk_fast_async, // internal fast rc, pin
  input wire logic meas_clk_tune_async, // tune filter result, pin
  input wire logic ref_12m_tick, // 12 MHz count enable, same domain
  output scs_osc_ctrl_t osc_ctrl, // oscillator trims and enables
  output scs_clk_en_t clk_en, // clock enables for the tree
  output logic slow_rc_run, // internal slow rc enable
  output logic watch_crystal_run, // watch crystal enable
  output scs_sleep_t sleep_level, // current sleep level
  output logic xtal_fail_nmi // one-cycle nmi pulse
);
  // ==========================================================
  // software registers
  logic [1:0] sleep_keep_r; // slow/watch keep bits
  logic [3:0] slow_trim_r; // slow rc tune
  logic [15:0] khz_div_r; // integer and fraction
  logic [3:0] bias_r; // crystal bias
  logic [4:0] fast_trim_r; // fast rc tune
  scs_meas_t meas_sel_r; // measurement source
  logic dither_r; // dither enable
  logic [1:0] xtal_r; // enable and source select
  logic cpu_rate_r; // cpu full rate when one
  logic [15:0] meas_res_r; // last measurement
  logic ack_r; // one wait state then answer
  logic fail_latched_r; // crystal source lost
  // ==========================================================
  // two-flop synchronisers for pins
  logic [5:0] sync1_r; // first stage, read only by stage two
  logic [5:0] sync2_r; // synchronised levels
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end
    else
    begin
      sync1_r <= {meas_clk_tune_async, meas_clk_fast_async,
                  meas_clk_slow_async, xtal_fail_async,
                  amp_high_async, amp_low_async};
      sync2_r <= sync1_r;
    end
  end
  wire logic amp_low_s = sync2_r[0];
  wire logic amp_high_s = sync2_r[1];
  wire logic xtal_fail_s = sync2_r[2];
  // ==========================================================
  // bus decode
  wire logic bus_req = avs_read | avs_write;
  wire logic wr_go = avs_write & ack_r;
  // byte-lane merge of write data into an old value
  function automatic logic [31:0] scs_merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[i*8 +: 8] = nw[i*8 +: 8];
    return res;
  endfunction
  wire logic [31:0] wmerge = scs_merge(SCS_READ_ZERO, avs_writedata,
                                       avs_byteenable);
  // divider keeps its old bytes where lanes are off
  wire logic [31:0] khz_merge = scs_merge({16'h0000, khz_div_r},
                                          avs_writedata, avs_byteenable);
  // ack toggles so each request waits exactly one cycle
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req & ~ack_r;
  end
  assign avs_waitrequest = bus_req & ~ack_r;
  // ==========================================================
  // register writes; only named bits stored
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sleep_keep_r <= SCS_RST_SLEEP_KEEP;
      slow_trim_r <= SCS_RST_SLOW_TRIM;
      khz_div_r <= SCS_RST_KHZ_DIV;
      bias_r <= SCS_RST_BIAS;
      fast_trim_r <= SCS_RST_FAST_TRIM;
      meas_sel_r <= SCS_MEAS_SLOW;
      dither_r <= 1'b0;
      cpu_rate_r <= 1'b0;
    end
    else if (wr_go)
    begin
      // partial byte enables only touch enabled lanes
      if (avs_address == SCS_OFF_SLEEP_KEEP && avs_byteenable[0])
        sleep_keep_r <= wmerge[1:0];
      else if (avs_address == SCS_OFF_SLOW_TRIM && avs_byteenable[0])
        slow_trim_r <= wmerge[3:0];
      else if (avs_address == SCS_OFF_KHZ_DIV)
        khz_div_r <= khz_merge[15:0];
      else if (avs_address == SCS_OFF_BIAS && avs_byteenable[0])
        bias_r <= wmerge[3:0];
      else if (avs_address == SCS_OFF_FAST_TRIM && avs_byteenable[0])
        fast_trim_r <= wmerge[4:0];
      else if (avs_address == SCS_OFF_MEAS_SEL && avs_byteenable[0])
        meas_sel_r <= scs_meas_t'(wmerge[1:0]);
      else if (avs_address == SCS_OFF_DITHER && avs_byteenable[0])
        dither_r <= wmerge[0];
      else if (avs_address == SCS_OFF_CPU && avs_byteenable[0])
        cpu_rate_r <= wmerge[0];
    end
  end
  // ==========================================================
  // crystal control with hardware failover
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      xtal_r <= 2'b00; // fast rc after reset
      fail_latched_r <= 1'b0;
    end
    else if (xtal_fail_s && xtal_r[SCS_BIT_SRC_SEL])
    begin
      // failure wins over a same-cycle software write
      xtal_r[SCS_BIT_SRC_SEL] <= 1'b0;
      xtal_r[SCS_BIT_XTAL_EN] <= xtal_r[SCS_BIT_XTAL_EN];
      fail_latched_r <= 1'b1;
    end
    else
    begin
      if (wr_go && avs_address == SCS_OFF_XTAL && avs_byteenable[0])
        xtal_r <= wmerge[1:0];
      if (!xtal_fail_s)
        fail_latched_r <= 1'b0;
    end
  end
  // nmi pulses once per failover event
  always_ff @(posedge core_clk)
  begin
    if (reset)
      xtal_fail_nmi <= 1'b0;
    else
      xtal_fail_nmi <= xtal_fail_s & xtal_r[SCS_BIT_SRC_SEL]
                       & ~fail_latched_r;
  end
  // ==========================================================
  // clock enables: divider phase gives glitch-free switching
  logic phase_r; // toggles every system clock
  logic src_act_r; // source in use, changes at phase zero
  logic cpu_full_act_r; // cpu full rate in use
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      phase_r <= 1'b0;
      src_act_r <= 1'b0;
      cpu_full_act_r <= 1'b0;
    end
    else
    begin
      phase_r <= ~phase_r;
      // only change on a whole-period boundary, no runt pulse
      if (phase_r)
      begin
        src_act_r <= xtal_r[SCS_BIT_SRC_SEL];
        // flash forces periph rate for cpu
        cpu_full_act_r <= cpu_rate_r & ~flash_busy;
      end
    end
  end
  // enables registered so they are glitch free
  always_ff @(posedge core_clk)
  begin
    if (reset)
      clk_en <= '0;
    else
    begin
      clk_en.sysclk_from_xtal <= src_act_r;
      clk_en.periph_en <= phase_r; // half rate
      clk_en.cpu_en <= cpu_full_act_r | phase_r;
      // ram double periph rate at slow cpu, periph rate at full
      clk_en.ram_en <= cpu_full_act_r ? phase_r : 1'b1;
    end
  end
  // ==========================================================
  // deep sleep level control
  always_ff @(posedge core_clk)
  begin
    if (reset)
      sleep_level <= SCS_AWAKE;
    else
    begin
      case (sleep_level)
        SCS_AWAKE:
          if (wait_for_interrupt && deep_sleep_request)
            sleep_level <= sleep_keep_r[SCS_BIT_SLOW_KEEP]
                           ? SCS_DEEP1 : SCS_DEEP2;
        default:
          if (wake_event)
            sleep_level <= SCS_AWAKE;
      endcase
    end
  end
  // oscillator run enables in sleep
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      slow_rc_run <= 1'b1;
      watch_crystal_run <= 1'b1;
    end
    else
    begin
      slow_rc_run <= (sleep_level != SCS_DEEP2);
      watch_crystal_run <= (sleep_level == SCS_AWAKE)
                           | sleep_keep_r[SCS_BIT_WATCH_KEEP];
    end
  end
  // oscillator control bundle from registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
      osc_ctrl <= '0;
    else
    begin
      osc_ctrl.slow_tune <= slow_trim_r;
      osc_ctrl.fast_tune <= fast_trim_r;
      osc_ctrl.bias <= bias_r;
      osc_ctrl.xtal_en <= xtal_r[SCS_BIT_XTAL_EN];
      osc_ctrl.dither_en <= dither_r;
      osc_ctrl.khz_int <= khz_div_r[15:11];
      osc_ctrl.khz_frac <= khz_div_r[10:0];
    end
  end
  // ==========================================================
  // period measurement: count 12 MHz ticks over n periods
  logic meas_prev_r; // previous measured level
  logic [8:0] per_cnt_r; // measured periods so far
  logic [15:0] tick_cnt_r; // 12 MHz ticks so far
  logic meas_lvl; // selected synchronised clock
  logic [8:0] per_target; // periods per result
  always_comb
  begin
    meas_lvl = 1'b0;
    per_target = SCS_SLOW_PERIODS;
    case (meas_sel_r)
      SCS_MEAS_SLOW: meas_lvl = sync2_r[3];
      SCS_MEAS_FAST:
      begin
        meas_lvl = sync2_r[4];
        per_target = SCS_FAST_PERIODS;
      end
      SCS_MEAS_TUNE: meas_lvl = sync2_r[5];
      default: meas_lvl = 1'b0; // unused: no edges
    endcase
  end
  // a select write starts the measurement over
  wire logic meas_sel_wr = wr_go && avs_address == SCS_OFF_MEAS_SEL
                           && avs_byteenable[0];
  wire logic meas_rise = meas_lvl & ~meas_prev_r;
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      meas_prev_r <= 1'b0;
      per_cnt_r <= 9'h000;
      tick_cnt_r <= 16'h0000;
      meas_res_r <= 16'h0000;
    end
    else
    begin
      // a fresh select waits for a whole low-high edge of the new source
      meas_prev_r <= meas_lvl | meas_sel_wr;
      if (meas_sel_wr)
      begin
        // restart so no result mixes periods of two sources
        per_cnt_r <= 9'h000;
        tick_cnt_r <= 16'h0000;
      end
      else if (meas_rise && per_cnt_r == per_target)
      begin
        meas_res_r <= tick_cnt_r;
        per_cnt_r <= 9'h001;
        tick_cnt_r <= {15'h0000, ref_12m_tick};
      end
      else
      begin
        if (meas_rise)
          per_cnt_r <= per_cnt_r + 9'h001;
        // the first edge opens the window and its own tick counts
        if (meas_rise && per_cnt_r == 9'h000)
          tick_cnt_r <= {15'h0000, ref_12m_tick};
        else if (per_cnt_r != 9'h000 && ref_12m_tick)
          tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
    end
  end
  // ==========================================================
  // read mux, reserved bits zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      avs_readdata <= SCS_READ_ZERO;
      avs_response_err <= 1'b0;
    end
    else
    begin
      avs_readdata <= SCS_READ_ZERO;
      avs_response_err <= 1'b0;
      if (avs_read && !ack_r)
      begin
        if (avs_address == SCS_OFF_SLEEP_KEEP)
          avs_readdata[1:0] <= sleep_keep_r;
        else if (avs_address == SCS_OFF_SLOW_TRIM)
          avs_readdata[3:0] <= slow_trim_r;
        else if (avs_address == SCS_OFF_KHZ_DIV)
          avs_readdata[15:0] <= khz_div_r;
        else if (avs_address == SCS_OFF_BIAS)
          avs_readdata[3:0] <= bias_r;
        else if (avs_address == SCS_OFF_FAST_TRIM)
          avs_readdata[4:0] <= fast_trim_r;
        else if (avs_address == SCS_OFF_LEVEL)
          avs_readdata[1:0] <= {amp_high_s, amp_low_s};
        else if (avs_address == SCS_OFF_MEAS_SEL)
          avs_readdata[1:0] <= meas_sel_r;
        else if (avs_address == SCS_OFF_MEAS_RES)
          avs_readdata[15:0] <= meas_res_r;
        else if (avs_address == SCS_OFF_DITHER)
          avs_readdata[0] <= dither_r;
        else if (avs_address == SCS_OFF_XTAL)
          avs_readdata[1:0] <= xtal_r;
        else if (avs_address == SCS_OFF_CPU)
          avs_readdata[0] <= cpu_rate_r;
        else
          avs_response_err <= 1'b1; // unmapped reads zero
      end
    end
  end
endmodule // scs_top
`default_nettype wire
